// [clk_startup_pkg.sv]
// Function
// - LF crystal wake delay 1K or 32K
// - LF crystal reset delay 14CK plus 0/4.1/65ms
// - source code 0010 selects calibrated RC oscillator
// - factory calibration loaded into trim at reset
// - software trim writes retune RC oscillator
// - RC source wakes in 6CK, reset delay table
// - reset pin disable lengthens 14CK to 4.1ms for RC and 128k sources only
// - reset timeout timed independent of system source
// - source code 0011 selects 128 kHz oscillator
// - 128k wakes in 6CK, 0/4/64ms reset delay
// - source code 0000 selects external clock pin
// - external clock wakes 6CK, 0/4.1/65ms reset delay
// - clock output fuse drives clock onto pin
// - clock output continues during start-up reset
// - clock output pin carries divided clock
// - clock output works with every source
// - divide-by-eight fuse divides clock by eight
// - prescaler resets to 0011 or 0000
package clk_startup_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   // reset time-outs in microseconds
   localparam int unsigned T_4P1_US = 4100;
   localparam int unsigned T_65_US = 65000;
   localparam int unsigned T_4_US = 4000;
   localparam int unsigned T_64_US = 64000;
   localparam int unsigned CYC_4P1 = T_4P1_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_65 = T_65_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_4 = T_4_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CYC_64 = T_64_US * (CLK_HZ / 1_000_000);
   // source clock counts
   localparam int unsigned CK_RESET = 14;
   localparam int unsigned CK_WAKE_SHORT = 6;
   localparam int unsigned CK_WAKE_1K = 1024;
   localparam int unsigned CK_WAKE_32K = 32768;
   // source select codes
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_RC = 4'h2;
   localparam logic [3:0] SRC_128K = 4'h3;
   localparam logic [2:0] SRC_LF_HI = 3'h3;
   // start-up codes
   localparam logic [1:0] STARTUP_14CK = 2'h0;
   localparam logic [1:0] STARTUP_FAST = 2'h1;
   // prescaler values
   localparam logic [3:0] PSC_DIV1 = 4'h0;
   localparam logic [3:0] PSC_DIV8 = 4'h3;
   localparam logic [3:0] PSC_MAX = 4'h8;
   // register byte offsets
   localparam logic [7:0] REG_TRIM = 8'h00;
   localparam logic [7:0] REG_PSC = 8'h04;
   localparam logic [7:0] REG_SLEEP = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   // status field positions
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_SRC_LSB = 4;
   localparam int unsigned STAT_STARTUP_LSB = 8;
   localparam int unsigned STAT_GATE_BIT = 12;
   // reset values
   localparam logic [7:0] TRIM_RST = 8'h00;

   typedef enum logic [1:0] {
      IDX_EXT = 2'b00,
      IDX_RC = 2'b01,
      IDX_LOWP = 2'b10,
      IDX_LF = 2'b11
   } src_idx_t;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_TMO = 3'b001,
      ST_CK = 3'b010,
      ST_RUN = 3'b011,
      ST_SLEEP = 3'b100
   } st_t;

   // map a source code to its oscillator; unknown codes fall back to rc
   function automatic src_idx_t src_index(input logic [3:0] code);
      src_idx_t idx;
      idx = IDX_RC;
      if (code == SRC_EXT) idx = IDX_EXT;
      else if (code == SRC_128K) idx = IDX_LOWP;
      else if (code[3:1] == SRC_LF_HI) idx = IDX_LF;
      return idx;
   endfunction
endpackage

// [clk_tick_if.sv]
`timescale 1ns/1ps
interface clk_tick_if;
   logic [3:0] src_code;
   logic src_edge;
   logic src_rise;
   logic [3:0] div_sel;
   logic div_tick;
   logic div_level;
   modport sync_mp(input src_code, output src_edge, output src_rise);
   modport div_mp(input src_edge, input div_sel, output div_tick, output div_level);
   modport ctl_mp(output src_code, output div_sel, input src_edge, input src_rise, input div_tick,
                  input div_level);
endinterface

// [osc_edge_sync.sv]
`timescale 1ns/1ps
module osc_edge_sync
   import clk_startup_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [3:0] osc_pins,
   clk_tick_if.sync_mp ifc
);
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic stable;
      logic edge_seen;
      logic rise;
   } sync_t;
   sync_t r, n;
   src_idx_t idx;

   // three-stage sync of all oscillators, edge of the selected one
   always_comb begin
      n = r;
      idx = src_index(ifc.src_code);
      n.s1 = osc_pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.edge_seen = 1'b0;
      n.rise = 1'b0;
      if (r.s2[idx] == r.s3[idx] && r.s3[idx] != r.stable) begin
         n.stable = r.s3[idx];
         n.edge_seen = 1'b1;
         n.rise = r.s3[idx];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) r <= '0;
      else r <= n;
   end

   assign ifc.src_edge = r.edge_seen;
   assign ifc.src_rise = r.rise;

   rc_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ifc.src_code == SRC_RC |-> idx == IDX_RC)
      else $error("rc code did not select rc oscillator");
endmodule

// [prescale_div.sv]
`timescale 1ns/1ps
module prescale_div
   import clk_startup_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   clk_tick_if.div_mp ifc
);
   typedef struct packed {
      logic [7:0] cnt;
      logic level;
      logic tick;
   } div_t;
   div_t r, n;
   logic [3:0] sh;
   logic [7:0] mask;

   // count half periods; reserved settings clamp to the largest factor
   always_comb begin
      n = r;
      n.tick = 1'b0;
      sh = (ifc.div_sel > PSC_MAX) ? PSC_MAX : ifc.div_sel;
      mask = 8'((9'h001 << sh) - 9'h001);
      if (ifc.src_edge) begin
         if (r.cnt >= mask) begin
            n.cnt = 8'h00;
            n.level = ~r.level;
            n.tick = ~r.level;
         end else begin
            n.cnt = r.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) r <= '0;
      else r <= n;
   end

   assign ifc.div_tick = r.tick;
   assign ifc.div_level = r.level;

   div1_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (ifc.div_sel == PSC_DIV1 && ifc.src_edge) |=> r.level != $past(r.level))
      else $error("undivided clock missed a source edge");
endmodule

// [clock_source_startup_select.sv]
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module clock_source_startup_select
   import clk_startup_pkg::*;
#(
   parameter int unsigned TMO_4P1_CYC = clk_startup_pkg::CYC_4P1,
   parameter int unsigned TMO_65_CYC = clk_startup_pkg::CYC_65,
   parameter int unsigned TMO_4_CYC = clk_startup_pkg::CYC_4,
   parameter int unsigned TMO_64_CYC = clk_startup_pkg::CYC_64
)
(
   input wire logic core_clk,
   input wire logic nrst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // oscillator inputs
   input wire logic crystal_input_pin,
   input wire logic rc_osc_in,
   input wire logic lowp_osc_in,
   input wire logic lf_osc_in,
   // fuses and factory data
   input wire logic [3:0] source_select_fuses,
   input wire logic [1:0] startup_time_fuses,
   input wire logic reset_pin_disable_fuse,
   input wire logic clock_output_fuse,
   input wire logic divide_by_eight_fuse,
   input wire logic [7:0] factory_cal,
   // wake request from sleep logic
   input wire logic wake_req,
   // outputs
   output logic sys_clk_en,
   output logic clock_output_pin,
   output logic clock_output_oe_n,
   output logic [7:0] rc_trim,
   output logic startup_busy
);
   typedef struct packed {
      st_t st;
      logic [23:0] tmo;
      logic [15:0] cnt;
      logic wake;
      logic [7:0] trim;
      logic [3:0] psc;
      logic [3:0] src_sel;
      logic [1:0] su_code;
      logic rstdis;
      logic out_fuse;
      logic ack;
      logic [31:0] rdat;
      logic clk_en;
      logic co_pin;
      logic co_oe_n;
      logic busy;
   } ctl_t;
   ctl_t r, n;
   clk_tick_if ifc();
   logic acc;
   logic wr;
   logic [23:0] tmo_tgt;
   logic [23:0] boot_tgt;
   int unsigned ck_tgt;

   // reset time-out in core cycles, timed independent of the selected source's clock
   function automatic logic [23:0] tmo_cycles(input logic [3:0] code, input logic [1:0] su_code,
                                              input logic rd);
      src_idx_t idx;
      logic internal;
      logic [23:0] t;
      idx = src_index(code);
      internal = (idx == IDX_RC) || (idx == IDX_LOWP);
      t = 24'h000000;
      if (su_code == STARTUP_14CK) begin
         if (rd && internal) t = 24'(TMO_4P1_CYC);
      end else if (su_code == STARTUP_FAST) begin
         t = (idx == IDX_LOWP) ? 24'(TMO_4_CYC) : 24'(TMO_4P1_CYC);
      end else begin
         t = (idx == IDX_LOWP) ? 24'(TMO_64_CYC) : 24'(TMO_65_CYC);
      end
      return t;
   endfunction

   // wake delay in source clocks
   function automatic int unsigned wake_clocks(input logic [3:0] code);
      int unsigned c;
      c = CK_WAKE_SHORT;
      if (src_index(code) == IDX_LF) c = code[0] ? CK_WAKE_32K : CK_WAKE_1K;
      return c;
   endfunction

   osc_edge_sync u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .osc_pins({lf_osc_in, lowp_osc_in, rc_osc_in, crystal_input_pin}),
      .ifc(ifc.sync_mp)
   );

   prescale_div u_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .ifc(ifc.div_mp)
   );

   assign ifc.src_code = r.src_sel;
   assign ifc.div_sel = r.psc;

   // delay targets
   always_comb begin
      tmo_tgt = tmo_cycles(r.src_sel, r.su_code, r.rstdis);
      boot_tgt = tmo_cycles(source_select_fuses, startup_time_fuses, reset_pin_disable_fuse);
      ck_tgt = r.wake ? wake_clocks(r.src_sel) : CK_RESET;
   end

   // bus slave, start-up sequencer and clock output
   always_comb begin
      n = r;
      n.ack = 1'b0;
      n.clk_en = 1'b0;
      acc = wb_cyc_i && wb_stb_i && !r.ack;
      wr = acc && wb_we_i && wb_sel_i[0];
      if (acc) begin
         n.ack = 1'b1;
         n.rdat = 32'h00000000;
         case (wb_adr_i)
            REG_TRIM: n.rdat[7:0] = r.trim;
            REG_PSC: n.rdat[3:0] = r.psc;
            REG_STATUS: begin
               n.rdat[STAT_STATE_LSB +: 3] = r.st;
               n.rdat[STAT_SRC_LSB +: 4] = r.src_sel;
               n.rdat[STAT_STARTUP_LSB +: 2] = r.su_code;
               n.rdat[STAT_GATE_BIT] = (r.st == ST_RUN);
            end
            default: n.rdat = 32'h00000000;
         endcase
      end
      if (wr && wb_adr_i == REG_TRIM) n.trim = wb_dat_i[7:0];
      if (wr && wb_adr_i == REG_PSC) n.psc = wb_dat_i[3:0];
      unique case (r.st)
         ST_BOOT: begin
            n.src_sel = source_select_fuses;
            n.su_code = startup_time_fuses;
            n.rstdis = reset_pin_disable_fuse;
            n.out_fuse = clock_output_fuse;
            n.trim = factory_cal;
            n.psc = divide_by_eight_fuse ? PSC_DIV8 : PSC_DIV1;
            n.tmo = 24'h000000;
            n.cnt = 16'h0000;
            n.wake = 1'b0;
            n.st = (boot_tgt == 24'h000000) ? ST_CK : ST_TMO;
         end
         ST_TMO: begin
            n.tmo = r.tmo + 24'h000001;
            if (r.tmo == tmo_tgt - 24'h000001) n.st = ST_CK;
         end
         ST_CK: begin
            if (ifc.src_rise) begin
               n.cnt = r.cnt + 16'h0001;
               if (r.cnt == 16'(ck_tgt - 1)) n.st = ST_RUN;
            end
         end
         ST_RUN: begin
            n.clk_en = ifc.div_tick;
            if (wr && wb_adr_i == REG_SLEEP && wb_dat_i[0]) n.st = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (wake_req) begin
               n.st = ST_CK;
               n.wake = 1'b1;
               n.cnt = 16'h0000;
            end
         end
         default: n.st = ST_BOOT;
      endcase
      n.busy = (n.st == ST_BOOT) || (n.st == ST_TMO) || (n.st == ST_CK);
      // pin keeps toggling through start-up, stops only in sleep
      n.co_pin = r.out_fuse && (r.st != ST_SLEEP) && ifc.div_level;
      n.co_oe_n = ~r.out_fuse;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
         r.trim <= TRIM_RST;
         r.co_oe_n <= 1'b1;
         r.busy <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign wb_dat_o = r.rdat;
   assign wb_ack_o = r.ack;
   assign sys_clk_en = r.clk_en;
   assign clock_output_pin = r.co_pin;
   assign clock_output_oe_n = r.co_oe_n;
   assign rc_trim = r.trim;
   assign startup_busy = r.busy;

   ack_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
      r.ack |=> !r.ack)
      else $error("ack held longer than one cycle");

   ack_resp_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (wb_cyc_i && wb_stb_i && !r.ack) |=> r.ack)
      else $error("bus request not acknowledged next cycle");

   trim_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
      r.st == ST_BOOT |=> r.trim == $past(factory_cal))
      else $error("factory calibration not loaded");

   trim_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (wr && wb_adr_i == REG_TRIM && r.st != ST_BOOT) |=> rc_trim == $past(wb_dat_i[7:0]))
      else $error("trim write not applied");

   psc_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
      r.st == ST_BOOT |=> r.psc == ($past(divide_by_eight_fuse) ? PSC_DIV8 : PSC_DIV1))
      else $error("prescaler reset value wrong");

   gate_run_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sys_clk_en |-> $past(r.st) == ST_RUN && $past(ifc.div_tick))
      else $error("system clock enabled outside run");

   clkout_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (r.out_fuse && r.st != ST_SLEEP) |=> !clock_output_oe_n && clock_output_pin == $past(ifc.div_level))
      else $error("clock output not driven");

   run_entry_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (r.st == ST_CK && ifc.src_rise && r.cnt == 16'(ck_tgt - 1)) |=> r.st == ST_RUN ##1 startup_busy == 1'b0)
      else $error("start-up count did not release clock");
endmodule

// [osc_source_model.sv]
`timescale 1ns/1ps
module osc_source_model (
   output logic crystal_input_pin,
   output logic rc_osc_in,
   output logic lowp_osc_in,
   output logic lf_osc_in
);
   // all sources start low
   initial begin
      crystal_input_pin = 1'b0;
      rc_osc_in = 1'b0;
      lowp_osc_in = 1'b0;
      lf_osc_in = 1'b0;
   end
   // fixed rates, no cycle to cycle drift
   always #48 crystal_input_pin = ~crystal_input_pin;
   always #56 rc_osc_in = ~rc_osc_in;
   always #88 lowp_osc_in = ~lowp_osc_in;
   always #40 lf_osc_in = ~lf_osc_in;
endmodule

// [clock_source_startup_select_tb.sv]
`timescale 1ns/1ps
module clock_source_startup_select_tb;
   import clk_startup_pkg::*;
   localparam int unsigned T41 = 200;
   localparam int unsigned T65 = 400;
   localparam int unsigned T4 = 150;
   localparam int unsigned T64 = 300;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic xin, rcin, lpin, lfin;
   logic [3:0] src = 4'h2;
   logic [1:0] st_fuse = 2'h0;
   logic rpd = 1'b0;
   logic cko = 1'b0;
   logic div8 = 1'b1;
   logic [7:0] cal = 8'hA5;
   logic wake_req = 1'b0;
   logic sys_clk_en, clk_pin, clk_oe_n, busy;
   logic [7:0] rc_trim;
   logic [31:0] rd;
   int unsigned err_total = 0;
   int unsigned n_checks = 0;
   int unsigned cnt;
   // source code, start-up code, reset pin disable, source period, time-out
   int unsigned tc [10][5] = '{'{2, 0, 0, 14, 0}, '{2, 1, 0, 14, T41}, '{2, 2, 0, 14, T65},
      '{2, 0, 1, 14, T41}, '{3, 1, 0, 22, T4}, '{3, 2, 0, 22, T64}, '{0, 2, 0, 12, T65},
      '{0, 0, 0, 12, 0}, '{6, 1, 0, 10, T41}, '{6, 2, 0, 10, T65}};

   always #4 core_clk = ~core_clk;

   osc_source_model osc (.crystal_input_pin(xin), .rc_osc_in(rcin), .lowp_osc_in(lpin), .lf_osc_in(lfin));

   clock_source_startup_select #(.TMO_4P1_CYC(T41), .TMO_65_CYC(T65), .TMO_4_CYC(T4), .TMO_64_CYC(T64)) DUT (
      .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .crystal_input_pin(xin), .rc_osc_in(rcin), .lowp_osc_in(lpin), .lf_osc_in(lfin),
      .source_select_fuses(src), .startup_time_fuses(st_fuse), .reset_pin_disable_fuse(rpd),
      .clock_output_fuse(cko), .divide_by_eight_fuse(div8), .factory_cal(cal), .wake_req(wake_req),
      .sys_clk_en(sys_clk_en), .clock_output_pin(clk_pin), .clock_output_oe_n(clk_oe_n), .rc_trim(rc_trim),
      .startup_busy(busy));

   task automatic conclude();
      if (err_total == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rng(input int unsigned got, input int unsigned lo, input int unsigned hi);
      n_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) err_total++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask

   // reset with the fuses of one table row, then time the start-up
   task automatic boot(input int unsigned i);
      int unsigned hi_cnt;
      nrst <= 1'b0;
      src <= 4'(tc[i][0]);
      st_fuse <= 2'(tc[i][1]);
      rpd <= tc[i][2][0];
      cko <= i[0];
      div8 <= ~i[0];
      cal <= 8'hA5 ^ 8'(i);
      repeat (20) @(posedge core_clk);
      chk(32'(rc_trim), 32'h0);
      nrst <= 1'b1;
      cnt = 0;
      hi_cnt = 0;
      do begin
         @(posedge core_clk);
         cnt++;
         hi_cnt += 32'(clk_pin === 1'b1);
      end while (busy !== 1'b0 && cnt < 5000);
      rng(cnt, tc[i][4] + 13 * tc[i][3], tc[i][4] + 14 * tc[i][3] + 12);
      chk(32'(hi_cnt != 0), 32'(i[0]));
      chk(32'(clk_oe_n), {31'h0, !i[0]});
      wb(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'h13F7, 32'h1003 | (tc[i][1] << 8) | (tc[i][0] << 4));
      wb(1'b0, REG_TRIM, 32'h0);
      chk(rd, 32'hA5 ^ i);
      wb(1'b0, REG_PSC, 32'h0);
      chk(rd, i[0] ? 32'h0 : 32'h3);
   endtask

   // spacing of system clock enables, after two settling pulses
   task automatic gap(input int unsigned exp);
      repeat (3) begin
         cnt = 0;
         do begin
            @(posedge core_clk);
            cnt++;
         end while (sys_clk_en !== 1'b1 && cnt < 3000);
      end
      chk(cnt, exp);
   endtask

   // power-down, then wake and time the wake-up count
   task automatic wake(input int unsigned lo, input int unsigned hi);
      logic seen;
      wb(1'b1, REG_SLEEP, 32'h1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(rd & 32'h7, 32'h4);
      chk(32'(clk_pin), 32'h0);
      wake_req <= 1'b1;
      seen = 1'b0;
      cnt = 0;
      do begin
         @(posedge core_clk);
         wake_req <= 1'b0;
         cnt++;
         seen |= (busy === 1'b1);
      end while (!(seen && busy === 1'b0) && cnt < 40000);
      rng(cnt, lo, hi);
   endtask

   // main sequence
   initial begin
      for (int i = 0; i < 10; i++) begin
         boot(i);
      end
      gap(10);
      wb(1'b1, REG_PSC, 32'h3);
      gap(80);
      wb(1'b1, REG_TRIM, 32'h3C);
      chk(32'(rc_trim), 32'h3C);
      wb(1'b0, REG_TRIM, 32'h0);
      chk(rd, 32'h3C);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      wake(1023 * 10, 1024 * 10 + 12);
      boot(0);
      wake(5 * 14, 6 * 14 + 12);
      conclude();
   end

   // watchdog against a hang
   initial begin
      #400000;
      err_total++;
      conclude();
   end
endmodule
